/* File: verilog/picc_pkg.sv */
// package of constants for the per-port classify and tag control bytes
// assumes an 8-bit register access port with 8-bit addresses
package picc_pkg;
  localparam int          PICC_PORTS      = 3;
  localparam int          PICC_AW         = 8;
  localparam int          PICC_DW         = 8;
  localparam logic [7:0]  PICC_ADDR_P1    = 8'h10;
  localparam logic [7:0]  PICC_ADDR_P2    = 8'h20;
  localparam logic [7:0]  PICC_ADDR_P3    = 8'h30;
  localparam int          PICC_BIT_STORM  = 7;
  localparam int          PICC_BIT_DSCP   = 6;
  localparam int          PICC_BIT_UPRIO  = 5;
  localparam int          PICC_BIT_PORTHI = 4;
  localparam int          PICC_BIT_CEIL   = 3;
  localparam int          PICC_BIT_TAGINS = 2;
  localparam int          PICC_BIT_TAGRM  = 1;
  localparam int          PICC_BIT_DUALQ  = 0;
  localparam logic [7:0]  PICC_RESET_FIXED = 8'h00;
  localparam logic [7:0]  PICC_STRAP_MASK  = 8'h37;
  localparam int          PICC_UP_W       = 3;
  localparam int          PICC_VID_W      = 12;
endpackage : picc_pkg

/* File: verilog/picc_ctrl_bank.sv */
// holds the three control bytes with registered read data
// assumes strap pins stable around reset release
`timescale 1ns/1ps
module picc_ctrl_bank (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         clk_en_i,
  input  wire logic                         load_i,
  input  wire logic [picc_pkg::PICC_PORTS*8-1:0] strap_i,
  input  wire logic                         wr_i,
  input  wire logic [1:0]                   wsel_i,
  input  wire logic [7:0]                   wdata_i,
  input  wire logic [1:0]                   rsel_i,
  output logic      [7:0]                   rdata_o,
  output logic      [picc_pkg::PICC_PORTS*8-1:0] ctrl_o
);
  import picc_pkg::*;
  typedef struct packed {
    logic [PICC_PORTS*8-1:0] ctrl;
    logic [7:0]              rdata;
  } picc_bank_s;
  picc_bank_s st_reg;
  picc_bank_s st_next;
  always_comb begin
    st_next = st_reg;
    for (int p = 0; p < PICC_PORTS; p++) begin
      if (load_i) begin
        st_next.ctrl[p*8 +: 8] = (strap_i[p*8 +: 8] & PICC_STRAP_MASK)
                                 | PICC_RESET_FIXED;
      end else if (wr_i && wsel_i == 2'(p)) begin
        st_next.ctrl[p*8 +: 8] = wdata_i;
      end
    end
    st_next.rdata = 8'h00;
    for (int p = 0; p < PICC_PORTS; p++) begin
      if (rsel_i == 2'(p)) begin
        st_next.rdata = st_reg.ctrl[p*8 +: 8];
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end
  assign rdata_o = st_reg.rdata;
  assign ctrl_o  = st_reg.ctrl;
endmodule : picc_ctrl_bank

/* File: verilog/picc_port_ctrl.sv */
// per-port classify and egress tag control bytes and their effects
// assumes packet descriptors arrive synchronous to ref_clk_i
// Operation
// - three identical control bytes at 0x10, 0x20, 0x30
// - bit 7 enables broadcast storm protection on ingress
// - bit 6 enables DiffServ priority classification
// - bit 5 enables 802.1p user priority classification
// - fallback priority is high when bit 4 set, else low
// - OR of DiffServ and 802.1p results overrides port priority
// - bit 3 caps user priority at default tag priority
// - bit 2 inserts tag on egress for untagged arrivals only
// - inserted tag uses ingress port default VID
// - bit 1 strips tag on egress from tagged arrivals
// - bit 0 splits output queue into high and low queues
// - bit 0 clear gives single queue without precedence
// - reset clears bits 7,6,3; others load from straps
`timescale 1ns/1ps
module picc_port_ctrl (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          clk_en_i,
  input  wire logic                          strap_port1_user_prio_class_en,
  input  wire logic                          strap_port2_user_prio_class_en,
  input  wire logic                          strap_port3_user_prio_class_en,
  input  wire logic                          strap_port1_default_high_prio,
  input  wire logic                          strap_port2_default_high_prio,
  input  wire logic                          strap_port3_default_high_prio,
  input  wire logic                          strap_port1_tag_insert,
  input  wire logic                          strap_port2_tag_insert,
  input  wire logic                          strap_port3_tag_insert,
  input  wire logic                          strap_port1_tag_strip,
  input  wire logic                          strap_port2_tag_strip,
  input  wire logic                          strap_port3_tag_strip,
  input  wire logic                          strap_port1_dual_queue,
  input  wire logic                          strap_port2_dual_queue,
  input  wire logic                          strap_port3_dual_queue,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [picc_pkg::PICC_AW-1:0]  reg_addr_i,
  input  wire logic [picc_pkg::PICC_DW-1:0]  reg_wdata_i,
  output logic      [picc_pkg::PICC_DW-1:0]  reg_rdata_o,
  output logic                               reg_rvalid_o,
  input  wire logic                          in_valid_i,
  input  wire logic [1:0]                    in_port_i,
  input  wire logic                          in_bcast_i,
  input  wire logic                          in_dscp_en_hit_i,
  input  wire logic                          in_dscp_high_i,
  input  wire logic                          in_tagged_i,
  input  wire logic                          in_uprio_high_i,
  input  wire logic [picc_pkg::PICC_UP_W-1:0] in_uprio_i,
  input  wire logic [picc_pkg::PICC_UP_W*3-1:0] dflt_uprio_i,
  input  wire logic [picc_pkg::PICC_VID_W*3-1:0] dflt_vid_i,
  output logic                               cls_valid_o,
  output logic                               cls_high_o,
  output logic                               cls_storm_check_o,
  output logic      [picc_pkg::PICC_UP_W-1:0] cls_uprio_o,
  input  wire logic                          eg_valid_i,
  input  wire logic [1:0]                    eg_port_i,
  input  wire logic [1:0]                    eg_src_port_i,
  input  wire logic                          eg_rx_tagged_i,
  output logic                               eg_valid_o,
  output logic                               eg_insert_o,
  output logic                               eg_strip_o,
  output logic      [picc_pkg::PICC_VID_W-1:0] eg_vid_o,
  output logic      [2:0]                    dual_queue_o
);
  import picc_pkg::*;

  typedef struct packed {
    logic                  boot;
    logic                  rvalid;
    logic                  cls_valid;
    logic                  cls_high;
    logic                  cls_storm;
    logic [PICC_UP_W-1:0]  cls_uprio;
    logic                  eg_valid;
    logic                  eg_insert;
    logic                  eg_strip;
    logic [PICC_VID_W-1:0] eg_vid;
    logic [2:0]            dualq;
  } picc_top_s;

  picc_top_s                 st_reg;
  picc_top_s                 st_next;
  logic [PICC_PORTS*8-1:0]   ctrl;
  logic [PICC_PORTS*8-1:0]   strap;
  logic [7:0]                bank_rdata;
  logic                      hit;
  logic [1:0]                sel;
  logic [7:0]                ic;
  logic [7:0]                ec;
  logic                      cls_hit;
  logic [PICC_UP_W-1:0]      cap;

  assign strap = {
    2'b00, strap_port3_user_prio_class_en, strap_port3_default_high_prio,
    1'b0, strap_port3_tag_insert, strap_port3_tag_strip,
    strap_port3_dual_queue,
    2'b00, strap_port2_user_prio_class_en, strap_port2_default_high_prio,
    1'b0, strap_port2_tag_insert, strap_port2_tag_strip,
    strap_port2_dual_queue,
    2'b00, strap_port1_user_prio_class_en, strap_port1_default_high_prio,
    1'b0, strap_port1_tag_insert, strap_port1_tag_strip,
    strap_port1_dual_queue};

  always_comb begin
    hit = 1'b1;
    sel = 2'd0;
    case (reg_addr_i)
      PICC_ADDR_P1: sel = 2'd0;
      PICC_ADDR_P2: sel = 2'd1;
      PICC_ADDR_P3: sel = 2'd2;
      default: begin
        hit = 1'b0;
        sel = 2'd3;
      end
    endcase
  end

  picc_ctrl_bank u_bank (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clk_en_i  (clk_en_i),
    .load_i    (st_reg.boot),
    .strap_i   (strap),
    .wr_i      (reg_wr_i && hit),
    .wsel_i    (sel),
    .wdata_i   (reg_wdata_i),
    .rsel_i    (sel),
    .rdata_o   (bank_rdata),
    .ctrl_o    (ctrl)
  );

  assign ic = ctrl[in_port_i*8 +: 8];
  assign ec = ctrl[eg_port_i*8 +: 8];

  always_comb begin
    st_next           = st_reg;
    st_next.boot      = 1'b0;
    st_next.rvalid    = reg_rd_i;
    st_next.cls_valid = in_valid_i && (in_port_i != 2'd3);
    cls_hit = (ic[PICC_BIT_DSCP] && in_dscp_en_hit_i)
           || (ic[PICC_BIT_UPRIO] && in_tagged_i);
    if (cls_hit) begin
      st_next.cls_high =
        (ic[PICC_BIT_DSCP] && in_dscp_en_hit_i && in_dscp_high_i)
        || (ic[PICC_BIT_UPRIO] && in_tagged_i && in_uprio_high_i);
    end else begin
      st_next.cls_high = ic[PICC_BIT_PORTHI];
    end
    st_next.cls_storm = ic[PICC_BIT_STORM] && in_bcast_i;
    cap = dflt_uprio_i[in_port_i*PICC_UP_W +: PICC_UP_W];
    if (ic[PICC_BIT_CEIL] && in_uprio_i > cap) begin
      st_next.cls_uprio = cap;
    end else begin
      st_next.cls_uprio = in_uprio_i;
    end
    st_next.eg_valid  = eg_valid_i && (eg_port_i != 2'd3);
    st_next.eg_insert = ec[PICC_BIT_TAGINS] && !eg_rx_tagged_i;
    st_next.eg_strip  = ec[PICC_BIT_TAGRM] && eg_rx_tagged_i;
    st_next.eg_vid    =
      dflt_vid_i[eg_src_port_i*PICC_VID_W +: PICC_VID_W];
    for (int p = 0; p < PICC_PORTS; p++) begin
      st_next.dualq[p] = ctrl[p*8 + PICC_BIT_DUALQ];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg      <= '0;
      st_reg.boot <= 1'b1;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o       = bank_rdata;
  assign reg_rvalid_o      = st_reg.rvalid;
  assign cls_valid_o       = st_reg.cls_valid;
  assign cls_high_o        = st_reg.cls_high;
  assign cls_storm_check_o = st_reg.cls_storm;
  assign cls_uprio_o       = st_reg.cls_uprio;
  assign eg_valid_o        = st_reg.eg_valid;
  assign eg_insert_o       = st_reg.eg_insert;
  assign eg_strip_o        = st_reg.eg_strip;
  assign eg_vid_o          = st_reg.eg_vid;
  assign dual_queue_o      = st_reg.dualq;
endmodule : picc_port_ctrl

/* File: verification/picc_chk_asserts.sv */
// checker on the classify, tag and register ports
// assumes a bind onto picc_port_ctrl, clk_en_i low only while idle
`timescale 1ns/1ps
module picc_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_rvalid_o,
  input wire logic        in_valid_i,
  input wire logic        in_bcast_i,
  input wire logic        cls_valid_o,
  input wire logic        eg_valid_i,
  input wire logic        eg_valid_o,
  input wire logic        cls_storm_check_o,
  input wire logic        eg_rx_tagged_i,
  input wire logic        eg_insert_o,
  input wire logic        eg_strip_o,
  input wire logic [1:0]  in_port_i,
  input wire logic [1:0]  eg_port_i,
  input wire logic [1:0]  eg_src_port_i,
  input wire logic [2:0]  in_uprio_i,
  input wire logic [2:0]  cls_uprio_o,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic [8:0]  dflt_uprio_i,
  input wire logic [11:0] eg_vid_o,
  input wire logic [35:0] dflt_vid_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_storm; cls_storm_check_o |-> $past(in_bcast_i); endproperty
  a_storm: assert property (p_storm) else $error("storm flag");
  property p_clsv; cls_valid_o == $past(in_valid_i && in_port_i != 2'h3);
  endproperty
  a_clsv: assert property (p_clsv) else $error("ingress valid");
  property p_egv; eg_valid_o == $past(eg_valid_i && eg_port_i != 2'h3);
  endproperty
  a_egv: assert property (p_egv) else $error("egress valid");
  property p_up; cls_valid_o |-> cls_uprio_o == $past(in_uprio_i) ||
    cls_uprio_o < $past(in_uprio_i) &&
    cls_uprio_o == $past(dflt_uprio_i[3*in_port_i +: 3]); endproperty
  a_up: assert property (p_up) else $error("user priority");
  property p_ins; eg_insert_o |-> !$past(eg_rx_tagged_i); endproperty
  a_ins: assert property (p_ins) else $error("insert");
  property p_strip; eg_strip_o |-> $past(eg_rx_tagged_i); endproperty
  a_strip: assert property (p_strip) else $error("strip");
  property p_vid; eg_valid_o |->
    eg_vid_o == $past(dflt_vid_i[12*eg_src_port_i +: 12]); endproperty
  a_vid: assert property (p_vid) else $error("vid");
  property p_rv; reg_rvalid_o == $past(reg_rd_i); endproperty
  a_rv: assert property (p_rv) else $error("read valid");
  property p_unm; reg_rvalid_o && !($past(reg_addr_i) inside
    {8'h10, 8'h20, 8'h30}) |-> reg_rdata_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  c_storm: cover property (cls_storm_check_o);
  c_ins: cover property (eg_insert_o);
  c_strip: cover property (eg_strip_o);
endmodule : picc_chk
bind picc_port_ctrl picc_chk i_chk (
  .ref_clk_i         (ref_clk_i),
  .rst_b_i           (rst_b_i),
  .reg_rd_i          (reg_rd_i),
  .reg_rvalid_o      (reg_rvalid_o),
  .in_valid_i        (in_valid_i),
  .in_bcast_i        (in_bcast_i),
  .cls_valid_o       (cls_valid_o),
  .eg_valid_i        (eg_valid_i),
  .eg_valid_o        (eg_valid_o),
  .cls_storm_check_o (cls_storm_check_o),
  .eg_rx_tagged_i    (eg_rx_tagged_i),
  .eg_insert_o       (eg_insert_o),
  .eg_strip_o        (eg_strip_o),
  .in_port_i         (in_port_i),
  .eg_port_i         (eg_port_i),
  .eg_src_port_i     (eg_src_port_i),
  .in_uprio_i        (in_uprio_i),
  .cls_uprio_o       (cls_uprio_o),
  .reg_addr_i        (reg_addr_i),
  .reg_rdata_o       (reg_rdata_o),
  .dflt_uprio_i      (dflt_uprio_i),
  .eg_vid_o          (eg_vid_o),
  .dflt_vid_i        (dflt_vid_i)
);

/* File: verification/tb_top.sv */
// bench for picc_port_ctrl, checked against a byte model
// assumes one-cycle registered answers, clk_en_i low for one idle write
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk_i, rst_b_i, clk_en_i, reg_wr_i, reg_rd_i, in_valid_i;
  logic        in_bcast_i, in_dscp_en_hit_i, in_dscp_high_i, in_tagged_i;
  logic        in_uprio_high_i, eg_valid_i, eg_rx_tagged_i, reg_rvalid_o;
  logic        cls_valid_o, cls_high_o, cls_storm_check_o, eg_valid_o;
  logic        eg_insert_o, eg_strip_o;
  logic [1:0]  in_port_i, eg_port_i, eg_src_port_i;
  logic [2:0]  in_uprio_i, cls_uprio_o, dual_queue_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, m [3];
  logic [8:0]  dflt_uprio_i;
  logic [11:0] eg_vid_o;
  logic [14:0] st;
  logic [35:0] dflt_vid_i;
  int          bad_count, checked, i;
  picc_port_ctrl i_dut (
    .strap_port1_user_prio_class_en(st[4]),
    .strap_port2_user_prio_class_en(st[9]),
    .strap_port3_user_prio_class_en(st[14]),
    .strap_port1_default_high_prio(st[3]),
    .strap_port2_default_high_prio(st[8]),
    .strap_port3_default_high_prio(st[13]),
    .strap_port1_tag_insert(st[2]), .strap_port2_tag_insert(st[7]),
    .strap_port3_tag_insert(st[12]), .strap_port1_tag_strip(st[1]),
    .strap_port2_tag_strip(st[6]), .strap_port3_tag_strip(st[11]),
    .strap_port1_dual_queue(st[0]), .strap_port2_dual_queue(st[5]),
    .strap_port3_dual_queue(st[10]), .*);
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [11:0] sn, ex);
    checked++;
    if (sn !== ex) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, sn, ex);
    end
  endtask : chk
  task automatic acc(input logic [7:0] ad, dt);
    logic hit;
    hit = ad inside {8'h10, 8'h20, 8'h30};
    @(posedge ref_clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, ad};
    @(posedge ref_clk_i);
    {reg_rd_i, reg_wr_i, reg_wdata_i} <= {2'b01, dt};
    #1;
    chk({reg_rvalid_o, reg_rdata_o},
        {1'b1, hit ? m[ad[5:4] - 1] : 8'h00});
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    if (hit) m[ad[5:4] - 1] = dt;
  endtask : acc
  task automatic pkt();
    logic [63:0] v;
    logic [31:0] r;
    logic [2:0]  cap;
    logic [1:0]  p, o, s;
    logic        d, t, hi;
    r = $urandom;
    v = {$urandom, $urandom};
    p = 2'(r[9:8] % 3);
    o = 2'(r[11:10] % 3);
    s = 2'(r[13:12] % 3);
    cap = v[36 + 3 * p +: 3];
    d = m[p][6] & r[1];
    t = m[p][5] & r[3];
    hi = (d | t) ? (d & r[2]) | (t & r[4]) : m[p][4];
    @(posedge ref_clk_i);
    {in_valid_i, eg_valid_i, eg_rx_tagged_i} <= {2'b11, r[14]};
    {in_port_i, eg_port_i, eg_src_port_i} <= {p, o, s};
    {dflt_uprio_i, dflt_vid_i} <= v[44:0];
    {in_uprio_i, in_uprio_high_i, in_tagged_i, in_dscp_high_i,
     in_dscp_en_hit_i, in_bcast_i} <= r[7:0];
    @(posedge ref_clk_i);
    {in_valid_i, eg_valid_i} <= 2'b00;
    #1;
    chk({cls_valid_o, cls_high_o}, {1'b1, hi});
    chk(cls_storm_check_o, m[p][7] & r[0]);
    chk(cls_uprio_o, (m[p][3] && r[7:5] > cap) ? cap : r[7:5]);
    chk({eg_valid_o, eg_insert_o, eg_strip_o},
        {1'b1, m[o][2] & ~r[14], m[o][1] & r[14]});
    chk(eg_vid_o, v[12 * s +: 12]);
    chk(dual_queue_o, {m[2][0], m[1][0], m[0][0]});
  endtask : pkt
  task automatic stop_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(32'h25E4085C));
    bad_count = 0;
    checked = 0;
    {ref_clk_i, rst_b_i, clk_en_i} = 3'b001;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, in_valid_i, in_port_i} = '0;
    {in_bcast_i, in_dscp_en_hit_i, in_dscp_high_i, in_tagged_i} = '0;
    {in_uprio_high_i, in_uprio_i, dflt_uprio_i, dflt_vid_i} = '0;
    {eg_valid_i, eg_port_i, eg_src_port_i, eg_rx_tagged_i} = '0;
    st = 15'($urandom);
    for (i = 0; i < 3; i++)
      m[i] = {2'b00, st[5 * i + 3 +: 2], 1'b0, st[5 * i +: 3]};
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    for (i = 0; i < 300; i++) begin
      acc(i % 4 == 3 ? 8'h11 : 8'(16 * (i % 4) + 16), 8'($urandom));
      repeat (2) pkt();
    end
    @(posedge ref_clk_i);
    {in_valid_i, eg_valid_i, in_port_i, eg_port_i} <= 6'b11_11_11;
    @(posedge ref_clk_i);
    {in_valid_i, eg_valid_i} <= 2'b00;
    #1;
    chk({cls_valid_o, eg_valid_o}, 2'b00);
    @(posedge ref_clk_i);
    {clk_en_i, reg_wr_i, reg_addr_i, reg_wdata_i} <= {2'b01, 8'h10, ~m[0]};
    @(posedge ref_clk_i);
    {clk_en_i, reg_wr_i} <= 2'b10;
    acc(8'h10, m[0]);
    stop_test();
  end
endmodule : tb_top
